// [core/ircm_top.sv]
/*
 Infrared carrier modulator: APB register file, prescaler, carrier generator,
 modulator and output stage. Assumes an APB master on pclk and an emitter
 driver on infrared_output_pin.
*/
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ircm_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic infrared_output_pin,
   output logic cycle_end_irq
);
   // Bus phase decode
   logic setup_ph;
   logic access_ph;
   logic [7:0] addr;
   // Software registers
   ircm_pkg::ircm_ctl_t ctl_r;
   logic [7:0] pri_high_r;
   logic [7:0] pri_low_r;
   logic [7:0] sec_high_r;
   logic [7:0] sec_low_r;
   logic [7:0] mark_period_high_byte_r;
   logic [7:0] mark_period_low_byte_r;
   logic [7:0] space_period_high_byte_r;
   logic [7:0] space_period_low_byte_r;
   logic output_latch_bit_r;
   logic output_polarity_r;
   // Flag and its clear sequence
   logic cycle_end_flag_r;
   logic clr_armed_r;
   // Engine state
   logic active_r;
   logic [2:0] presc_cnt_r;
   logic [2:0] mod_div_r;
   logic [7:0] cg_cnt_r;
   ircm_pkg::ircm_phase_t cg_phase_r;
   logic fsk_sec_r;
   logic [16:0] mod_cnt_r;
   logic [15:0] space_r;
   logic exsp_cycle_r;
   // Combinational strobes
   logic start;
   logic tick;
   logic [2:0] presc_last;
   logic cg_run;
   logic [7:0] cg_cmp;
   logic cg_match;
   logic carrier_end;
   logic mod_tick;
   logic cycle_end;
   // Count that the modulator tick about to happen leaves behind
   logic [16:0] mod_cnt_dec;
   logic carrier;
   logic tx;
   logic pin_nxt;
   logic [31:0] rd_nxt;
   logic hit;

   assign setup_ph = psel & ~penable;
   assign access_ph = psel & penable & pready;
   assign addr = paddr[7:0];

   // Address decode for the read mux and error answer
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      hit = 1'b1;
      unique case (addr)
         ircm_pkg::OFS_PRI_HIGH: rd_nxt[7:0] = pri_high_r;
         ircm_pkg::OFS_PRI_LOW: rd_nxt[7:0] = pri_low_r;
         ircm_pkg::OFS_SEC_HIGH: rd_nxt[7:0] = sec_high_r;
         ircm_pkg::OFS_SEC_LOW: rd_nxt[7:0] = sec_low_r;
         ircm_pkg::OFS_STATUS_CONTROL: rd_nxt[7:0] = {cycle_end_flag_r, ctl_r};
         ircm_pkg::OFS_MARK_HIGH: rd_nxt[7:0] = mark_period_high_byte_r;
         ircm_pkg::OFS_MARK_LOW: rd_nxt[7:0] = mark_period_low_byte_r;
         ircm_pkg::OFS_SPACE_HIGH: rd_nxt[7:0] = space_period_high_byte_r;
         ircm_pkg::OFS_SPACE_LOW: rd_nxt[7:0] = space_period_low_byte_r;
         ircm_pkg::OFS_OUTPUT_CONTROL: rd_nxt[1:0] = {output_polarity_r, output_latch_bit_r};
         default: hit = 1'b0;
      endcase
      // Only aligned words are mapped
      if (paddr[31:8] != 24'h00_0000 || paddr[1:0] != 2'h0)
      begin
         hit = 1'b0;
         rd_nxt = 32'h0000_0000;
      end
   end

   // APB answer: prepared in setup, so the access phase takes one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_ph;
         pslverr <= setup_ph & ~hit;
         prdata <= (setup_ph & ~pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   // Control register writes; mode bits are not double buffered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctl_r <= ircm_pkg::RST_CTL;
      else if (access_ph && pwrite && hit && addr == ircm_pkg::OFS_STATUS_CONTROL)
         ctl_r <= ircm_pkg::ircm_ctl_t'(pwdata[6:0]);
   end

   // Carrier count and modulator data buffers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pri_high_r <= ircm_pkg::RST_COUNT;
         pri_low_r <= ircm_pkg::RST_COUNT;
         sec_high_r <= ircm_pkg::RST_COUNT;
         sec_low_r <= ircm_pkg::RST_COUNT;
         mark_period_high_byte_r <= ircm_pkg::RST_DATA;
         mark_period_low_byte_r <= ircm_pkg::RST_DATA;
         space_period_high_byte_r <= ircm_pkg::RST_DATA;
         space_period_low_byte_r <= ircm_pkg::RST_DATA;
         output_latch_bit_r <= ircm_pkg::RST_OUTCTL[ircm_pkg::OUTCTL_LATCH_BIT];
         output_polarity_r <= ircm_pkg::RST_OUTCTL[ircm_pkg::OUTCTL_POLARITY_BIT];
      end
      else if (access_ph && pwrite && hit)
      begin
         // Buffers may change any time; the engine samples mark and space at reload, carrier counts live
         unique case (addr)
            ircm_pkg::OFS_PRI_HIGH: pri_high_r <= pwdata[7:0];
            ircm_pkg::OFS_PRI_LOW: pri_low_r <= pwdata[7:0];
            ircm_pkg::OFS_SEC_HIGH: sec_high_r <= pwdata[7:0];
            ircm_pkg::OFS_SEC_LOW: sec_low_r <= pwdata[7:0];
            ircm_pkg::OFS_MARK_HIGH: mark_period_high_byte_r <= pwdata[7:0];
            ircm_pkg::OFS_MARK_LOW: mark_period_low_byte_r <= pwdata[7:0];
            ircm_pkg::OFS_SPACE_HIGH: space_period_high_byte_r <= pwdata[7:0];
            ircm_pkg::OFS_SPACE_LOW: space_period_low_byte_r <= pwdata[7:0];
            ircm_pkg::OFS_OUTPUT_CONTROL:
            begin
               output_latch_bit_r <= pwdata[ircm_pkg::OUTCTL_LATCH_BIT];
               output_polarity_r <= pwdata[ircm_pkg::OUTCTL_POLARITY_BIT];
            end
            default: ;
         endcase
      end
   end

   assign start = ctl_r.modulator_enable & ~active_r;

   assign presc_last = 3'((4'h1 << ctl_r.prescale) - 4'h1);
   assign tick = active_r && (presc_cnt_r == presc_last);

   // Prescaler; halted while idle to save power
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc_cnt_r <= 3'h0;
      else if (!active_r || start)
         presc_cnt_r <= 3'h0;
      else if (tick)
         presc_cnt_r <= 3'h0;
      else
         presc_cnt_r <= presc_cnt_r + 3'h1;
   end

   assign cg_run = tick & ~ctl_r.baseband_select;
   assign cg_cmp = (cg_phase_r == ircm_pkg::CG_HIGH)
                   ? (fsk_sec_r ? sec_high_r : pri_high_r)
                   : (fsk_sec_r ? sec_low_r : pri_low_r);
   assign cg_match = cg_run && (cg_cnt_r == cg_cmp);
   assign carrier_end = cg_match && (cg_phase_r == ircm_pkg::CG_LOW);

   // Carrier generator: up counter restarts at one on each compare
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cg_cnt_r <= ircm_pkg::CG_START;
         cg_phase_r <= ircm_pkg::CG_HIGH;
      end
      else if (start)
      begin
         cg_cnt_r <= ircm_pkg::CG_START;
         cg_phase_r <= ircm_pkg::CG_HIGH;
      end
      else if (cg_match)
      begin
         cg_cnt_r <= ircm_pkg::CG_START;
         cg_phase_r <= (cg_phase_r == ircm_pkg::CG_HIGH) ? ircm_pkg::CG_LOW : ircm_pkg::CG_HIGH;
      end
      else if (cg_run)
         cg_cnt_r <= cg_cnt_r + 8'h01;
   end

   assign carrier = ctl_r.baseband_select | (cg_phase_r == ircm_pkg::CG_HIGH);

   // Divide by eight for time and baseband modulator counts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mod_div_r <= 3'h0;
      else if (start)
         mod_div_r <= 3'h0;
      else if (tick)
         mod_div_r <= mod_div_r + 3'h1;
   end

   assign mod_tick = (ctl_r.fsk_select & ~ctl_r.baseband_select)
                     ? carrier_end
                     : (tick && mod_div_r == ircm_pkg::MOD_DIV_LAST);

   assign mod_cnt_dec = mod_cnt_r - 17'h0_0001;
   // Space is matched on the count this tick produces, so a zero space ends the
   // cycle as the mark runs out and leaves no gap; space then lasts space ticks
   assign cycle_end = active_r & mod_tick & mod_cnt_dec[16] & (~mod_cnt_dec[15:0] == space_r);

   // Modulator down counter and space register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mod_cnt_r <= 17'h0_0000;
         space_r <= 16'h0000;
      end
      else if (start || cycle_end)
      begin
         mod_cnt_r <= {1'b0, mark_period_high_byte_r, mark_period_low_byte_r};
         space_r <= {space_period_high_byte_r, space_period_low_byte_r};
      end
      else if (active_r && mod_tick)
         mod_cnt_r <= mod_cnt_dec;
   end

   // Run state, FSK set select and extended-space cycle marker
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         active_r <= 1'b0;
         fsk_sec_r <= 1'b0;
         exsp_cycle_r <= 1'b0;
      end
      else if (start)
      begin
         active_r <= 1'b1;
         fsk_sec_r <= 1'b0;
         exsp_cycle_r <= ctl_r.extended_space_enable;
      end
      else if (cycle_end)
      begin
         active_r <= ctl_r.modulator_enable;
         fsk_sec_r <= fsk_sec_r ^ (ctl_r.fsk_select & ~ctl_r.baseband_select);
         exsp_cycle_r <= ctl_r.extended_space_enable;
      end
   end

   // Flag clear sequence: a status read arms, a low-byte access clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clr_armed_r <= 1'b0;
      else if (access_ph && !pwrite && addr == ircm_pkg::OFS_STATUS_CONTROL)
         clr_armed_r <= 1'b1;
      else if (access_ph && (addr == ircm_pkg::OFS_MARK_LOW || addr == ircm_pkg::OFS_SPACE_LOW))
         clr_armed_r <= 1'b0;
   end

   // End-of-cycle flag; a set in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cycle_end_flag_r <= 1'b0;
      else if (start || cycle_end)
         cycle_end_flag_r <= 1'b1;
      else if (clr_armed_r && access_ph &&
               (addr == ircm_pkg::OFS_MARK_LOW || addr == ircm_pkg::OFS_SPACE_LOW))
         cycle_end_flag_r <= 1'b0;
   end

   assign tx = ~mod_cnt_r[16] & ~exsp_cycle_r & carrier;

   // Output stage selects transmitter or latch bit
   always_comb
   begin
      if (active_r)
         pin_nxt = output_polarity_r ? tx : ~tx;
      else
         pin_nxt = output_latch_bit_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         infrared_output_pin <= 1'b0;
      else
         infrared_output_pin <= pin_nxt;
   end

   // Interrupt request, registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cycle_end_irq <= 1'b0;
      else
         cycle_end_irq <= cycle_end_flag_r & ctl_r.cycle_end_irq_enable;
   end

endmodule // ircm_top
`default_nettype wire

// [core/ircm_pkg.sv]
/*
 Constants, register map and field layout of the infrared carrier modulator.
 Assumes a single pclk domain and an APB slave with 32-bit data, byte addresses.
*/
// Function
// - baseband holds carrier at active level, generator stopped
// - without baseband, carrier toggles per high/low counts
// - baseband select cleared by reset
// - FSK select chooses time/baseband or FSK
// - interrupt request when flag and enable set
// - enable initializes and runs generator and modulator
// - disable finishes current cycle, then stops, output to latch bit
// - period buffers load only at enable and at cycle completion
// - prescaler divides input clock by 1,2,4,8
// - carrier counts in one prescaled-clock steps
// - time mode high and low counts independent
// - FSK swaps count sets on modulator signal
// - modulator counts prescaled clocks divided by 8, or carrier periods
// - modulator output reaches pin while enabled
// - time mode gates primary carrier onto pin
// - baseband mode drives pin from gate only
// - FSK mode alternates sets, carrier gated
// - extended space keeps output deasserted whole cycle
// - disabled pin follows software output latch bit
// - flag set at start and cycle end, read-then-access clears
// - polarity bit selects pin active level
// - prescale field decode 00..11 gives 1..8
package ircm_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_PRI_HIGH = 8'h00;
   localparam logic [7:0] OFS_PRI_LOW = 8'h04;
   localparam logic [7:0] OFS_SEC_HIGH = 8'h08;
   localparam logic [7:0] OFS_SEC_LOW = 8'h0C;
   localparam logic [7:0] OFS_STATUS_CONTROL = 8'h10;
   localparam logic [7:0] OFS_MARK_HIGH = 8'h14;
   localparam logic [7:0] OFS_MARK_LOW = 8'h18;
   localparam logic [7:0] OFS_SPACE_HIGH = 8'h1C;
   localparam logic [7:0] OFS_SPACE_LOW = 8'h20;
   localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h24;
   // Output control fields
   localparam int OUTCTL_LATCH_BIT = 0;
   localparam int OUTCTL_POLARITY_BIT = 1;
   // Reset values
   localparam logic [7:0] RST_COUNT = 8'h01;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [1:0] RST_OUTCTL = 2'h0;
   // Last divider value: eight prescaled clocks per modulator count in time and baseband modes
   localparam logic [2:0] MOD_DIV_LAST = 3'h7;
   // Carrier counter restart value
   localparam logic [7:0] CG_START = 8'h01;
   // Control bits of the status/control register, bits 6..0
   typedef struct packed {
      logic [1:0] prescale;
      logic extended_space_enable;
      logic baseband_select;
      logic fsk_select;
      logic cycle_end_irq_enable;
      logic modulator_enable;
   } ircm_ctl_t;
   localparam ircm_ctl_t RST_CTL = '0;
   // Carrier generator phase
   typedef enum logic {CG_HIGH, CG_LOW} ircm_phase_t;
endpackage

// [test/ircm_properties.sv]
/*
 Port checker for ircm_top.
 Assumes one pclk domain and an APB master.
*/
`timescale 1ns/1ps
`default_nettype none
module ircm_properties
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic infrared_output_pin,
   input wire logic cycle_end_irq
);
   // Control and output bits as last written
   logic [6:0] ctl_r;
   logic [1:0] out_r;
   // Any write taken since reset
   logic wr_seen_r;
   // Shadow the writes; refused ones are skipped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl_r <= 7'h00;
         out_r <= 2'h0;
         wr_seen_r <= 1'b0;
      end
      else if (pready && pwrite && !pslverr)
      begin
         wr_seen_r <= 1'b1;
         if (paddr[7:0] == 8'h10) ctl_r <= pwdata[6:0];
         if (paddr[7:0] == 8'h24) out_r <= pwdata[1:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_one:
      assert property (psel && !penable |=> pready ##1 !pready) else $error("pready shape");
   chk_err_unmapped:
      assert property (psel && !penable && (paddr > 32'h24 || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("unmapped not refused");
   chk_err_mapped:
      assert property (psel && !penable && paddr == 32'h10 |=> !pslverr) else $error("bad pslverr");
   chk_rdata_idle:
      assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
   chk_ctl_readback:
      assert property (pready && !pwrite && paddr == 32'h10 |-> prdata[6:0] == ctl_r)
      else $error("control readback");
   chk_pol_readback:
      assert property (pready && !pwrite && paddr == 32'h24 |-> prdata[1:0] == out_r)
      else $error("output control readback");
   chk_irq_match:
      assert property (pready && !pwrite && paddr == 32'h10 |-> cycle_end_irq == (prdata[7] && prdata[1]))
      else $error("irq not flag and enable");
   chk_irq_gated:
      assert property (!ctl_r[1] && $past(!ctl_r[1]) |-> !cycle_end_irq) else $error("irq while masked");
   chk_quiet_start:
      assert property (!wr_seen_r |-> !infrared_output_pin) else $error("pin moved before write");
endmodule // ircm_properties
bind ircm_top ircm_properties ircm_properties_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .infrared_output_pin(infrared_output_pin),
   .cycle_end_irq(cycle_end_irq));
`default_nettype wire

// [test/ircm_emitter_model.sv]
/*
 Emitter driver model: times the high and low runs of the pin.
 Assumes the pin is a level in the pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module ircm_emitter_model
(
   input wire logic pclk,
   input wire logic drive,
   input wire logic clr,
   output logic [15:0] hi_len,
   output logic [15:0] lo_len,
   output logic [15:0] hi_max,
   output logic [15:0] rises
);
   // Previous level and length of the running level
   logic last_r;
   logic [15:0] run_r;
   // Record each finished run; clr restarts the statistics
   always_ff @(posedge pclk)
   begin
      last_r <= drive;
      run_r <= clr ? 16'h0 : (drive == last_r) ? run_r + 16'h1 : 16'h1;
      if (clr)
      begin
         hi_max <= 16'h0;
         rises <= 16'h0;
      end
      else if (drive && !last_r)
      begin
         lo_len <= run_r;
         rises <= rises + 16'h1;
      end
      else if (!drive && last_r)
      begin
         hi_len <= run_r;
         if (run_r > hi_max) hi_max <= run_r;
      end
   end
endmodule // ircm_emitter_model
`default_nettype wire

// [test/tb.sv]
/*
 Self-checking bench: APB tasks and mode runs of ircm_top.
 Assumes a zero wait-state slave and the emitter model on the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Bench drive and design outputs
   logic pclk, presetn, psel, penable, pwrite, clr, pready, pslverr, pin, irq, err;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [15:0] hi_len, lo_len, hi_max, rises;
   // Control value of the latest run, so a stop keeps its mode bits
   logic [7:0] mode;
   // Counts: pri high/low, sec high/low, control, mark, space
   logic [31:0] cfg [9] = '{2, 3, 3, 1, 0, 0, 1, 0, 1};
   int bad_count = 0;
   int n_checks = 0;
   ircm_top ircm_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .infrared_output_pin(pin), .cycle_end_irq(irq));
   ircm_emitter_model ircm_emitter_model_inst (.pclk(pclk), .drive(pin), .clr(clr),
      .hi_len(hi_len), .lo_len(lo_len), .hi_max(hi_max), .rises(rises));
   // 100 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) bad_count++;
      if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      check(q, exp);
   endtask
   // Enable with a mode, restart pin statistics, let it run
   task automatic run(input logic [7:0] c, input int n);
      mode = c;
      xfer(1'b1, 8'h10, {24'h0, c});
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(n);
   endtask
   // Disable with the mode bits kept; the running cycle must finish within n
   task automatic stop(input int n);
      xfer(1'b1, 8'h10, {24'h0, mode & 8'hFE});
      tick(n);
      check({31'h0, pin}, 32'h0);
      // Mode bits are cleared only once the engine has gone idle
      xfer(1'b1, 8'h10, 32'h0);
   endtask
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog, well above the whole sequence
   initial
   begin
      tick(20000);
      bad_count++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, clr} = '0;
      tick(16);
      presetn <= 1'b1;
      for (int i = 0; i < 10; i++) rc(8'(i * 4), (i < 4) ? 32'h1 : 32'h0);
      xfer(1'b0, 8'h28, 32'h0);
      check({31'h0, err}, 32'h1);
      // Latch bit drives the idle pin, polarity ignored
      xfer(1'b1, 8'h24, 32'h1);
      tick(3);
      check({31'h0, pin}, 32'h1);
      xfer(1'b1, 8'h24, 32'h2);
      tick(3);
      check({31'h0, pin}, 32'h0);
      foreach (cfg[i]) xfer(1'b1, 8'(i * 4), cfg[i]);
      // Baseband: mark 16 and space 8 prescaled clocks per prescale step
      for (int p = 0; p < 4; p++)
      begin
         run(8'(p * 32 + 9), 72 << p);
         check(32'(hi_len), 32'(16 << p));
         check(32'(lo_len), 32'(8 << p));
         stop((24 << p) + 10);
         rc(8'h10, 32'h80);
      end
      // Mark buffer change lands at the next cycle
      run(8'h09, 20);
      xfer(1'b1, 8'h18, 32'h3);
      tick(120);
      check(32'(hi_len), 32'd32);
      // Active low: space shows as the high run
      xfer(1'b1, 8'h24, 32'h0);
      run(8'h09, 120);
      check(32'(hi_len), 32'd8);
      check(32'(lo_len), 32'd32);
      stop(50);
      xfer(1'b1, 8'h24, 32'h2);
      xfer(1'b1, 8'h18, 32'h1);
      // Time mode: primary carrier, two-clock high pulses
      run(8'h01, 100);
      check(32'(hi_max), 32'd2);
      check(32'(rises > 0), 32'h1);
      stop(40);
      // FSK, zero mark and space: secondary high of 3 appears
      xfer(1'b1, 8'h18, 32'h0);
      xfer(1'b1, 8'h20, 32'h0);
      run(8'h05, 100);
      check(32'(hi_max), 32'd3);
      stop(40);
      xfer(1'b1, 8'h18, 32'h1);
      xfer(1'b1, 8'h20, 32'h1);
      // Extended space silences the pin until cleared
      run(8'h09, 30);
      xfer(1'b1, 8'h10, 32'h19);
      run(8'h19, 100);
      check(32'(rises), 32'h0);
      xfer(1'b1, 8'h10, 32'h09);
      tick(60);
      check(32'(rises > 0), 32'h1);
      stop(40);
      // Flag clear sequence, then interrupt on and masked
      rc(8'h10, 32'h80);
      rc(8'h18, 32'h1);
      rc(8'h10, 32'h0);
      check({31'h0, irq}, 32'h0);
      run(8'h0B, 4);
      check({31'h0, irq}, 32'h1);
      rc(8'h10, 32'h8B);
      xfer(1'b1, 8'h10, 32'h09);
      tick(3);
      check({31'h0, irq}, 32'h0);
      stop(40);
      give_verdict();
   end
endmodule // tb
`default_nettype wire
